/* cap_word_rom.sv */
`timescale 1ns/10ps

module cap_word_rom
    import ehci_cap_pkg::*;
#(
    parameter logic [15:0] versionBcd  = VERSION_BCD,
    parameter logic [7:0]  capability_byte_length   = CAP_BYTE_LENGTH,
    parameter logic [3:0]  companions  = COMPANIONS,
    parameter logic [3:0]  portsPerCc  = PORTS_PER_COMP,
    parameter logic        routingRule = ROUTING_RULE,
    parameter logic        powerSwitch = POWER_SWITCHES,
    parameter logic [3:0]  nPorts      = DOWNSTREAM_PORTS
) (
    // Clock and reset
    input  wire logic                  core_clk,
    input  wire logic                  nrst,
    // Read request
    input  wire logic                  rdEn,
    input  wire logic [WORD_SEL_W-1:0] wordSel,
    // Registered read data
    output logic      [DATA_W-1:0]     rdData
);

    typedef struct packed {
        logic [DATA_W-1:0] rdData;
    } rom_state_t;

    rom_state_t state;
    rom_state_t next_state;
    logic [DATA_W-1:0] capWord0;
    logic [DATA_W-1:0] structWord;

    // ==========================================================
    // Constant words, reserved bits held at zero
    always_comb begin
        capWord0                                 = WORD_ZERO;
        capWord0[VERSION_LSB +: 16]              = versionBcd;
        capWord0[CAPLEN_LSB +: 8]                = capability_byte_length;
        structWord                               = WORD_ZERO;
        structWord[NCC_LSB +: FIELD_W]           = companions;
        structWord[NPCC_LSB +: FIELD_W]          = portsPerCc;
        structWord[ROUTING_BIT]                  = routingRule;
        structWord[POWER_BIT]                    = powerSwitch;
        structWord[NPORTS_LSB +: FIELD_W]        = nPorts;
    end

    // ==========================================================
    // Word select; anything unmapped reads zero
    always_comb begin
        next_state = state;
        next_state.rdData = WORD_ZERO;
        if (rdEn) begin
            if (wordSel == CAP_WORD0_OFFSET[ADDR_W-1:2]) begin
                next_state.rdData = capWord0;
            end else if (wordSel == STRUCT_OFFSET[ADDR_W-1:2]) begin
                next_state.rdData = structWord;
            end
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign rdData = state.rdData;

endmodule

/* ehci_cap_pkg.sv */
package ehci_cap_pkg;

    // ==========================================================
    // Bus widths and register offsets
    localparam int             ADDR_W           = 8;
    localparam int             DATA_W           = 32;
    localparam int             WORD_SEL_W       = ADDR_W - 2;
    localparam logic [7:0]     CAP_BASE_OFFSET  = 8'h00;
    localparam logic [7:0]     CAP_WORD0_OFFSET = 8'h00;
    localparam logic [7:0]     STRUCT_OFFSET    = 8'h04;

    // ==========================================================
    // Field positions
    localparam int             VERSION_LSB      = 16;
    localparam int             CAPLEN_LSB       = 0;
    localparam int             NCC_LSB          = 12;
    localparam int             NPCC_LSB         = 8;
    localparam int             ROUTING_BIT      = 7;
    localparam int             POWER_BIT        = 4;
    localparam int             NPORTS_LSB       = 0;
    localparam int             FIELD_W          = 4;

    // ==========================================================
    // Values presented by the bank
    localparam logic [15:0]    VERSION_BCD      = 16'h0100;
    localparam logic [7:0]     CAP_BYTE_LENGTH  = 8'h20;
    localparam logic [3:0]     COMPANIONS       = 4'h1;
    localparam logic [3:0]     PORTS_PER_COMP   = 4'h2;
    localparam logic           ROUTING_RULE     = 1'b1;
    localparam logic           POWER_SWITCHES   = 1'b1;
    localparam logic [3:0]     DOWNSTREAM_PORTS = 4'h2;

    // ==========================================================
    // Timing and sizing
    localparam int             READ_LATENCY     = 2;
    localparam int             MAX_PORTS        = 15;
    localparam logic [31:0]    WORD_ZERO        = 32'h00000000;

endpackage

/* ehci_capability_registers.sv */
`timescale 1ns/10ps

module ehci_capability_registers
    import ehci_cap_pkg::*;
#(
    parameter logic [15:0] versionBcd  = VERSION_BCD,
    parameter logic [7:0]  capability_byte_length   = CAP_BYTE_LENGTH,
    parameter logic [3:0]  companions  = COMPANIONS,
    parameter logic [3:0]  portsPerCc  = PORTS_PER_COMP,
    parameter logic        routingRule = ROUTING_RULE,
    parameter logic        powerSwitch = POWER_SWITCHES,
    parameter logic [3:0]  nPorts      = DOWNSTREAM_PORTS
) (
    // Clock and reset
    input  wire logic                        core_clk,
    input  wire logic                        nrst,
    // Register access from the host bus
    input  wire logic                        regRead,
    input  wire logic                        regWrite,
    input  wire logic [ADDR_W-1:0]           regAddr,
    input  wire logic [DATA_W-1:0]           regWdata,
    output logic      [DATA_W-1:0]           regRdata,
    output logic                             regAck,
    // Structural strap outputs for the rest of the controller
    output logic                             handoffSupported,
    output logic                             highSpeedOnly,
    output logic                             explicitRouting,
    output logic                             powerSwitchPresent,
    output logic      [MAX_PORTS-1:0]        portAddressable,
    output logic      [MAX_PORTS*FIELD_W-1:0] portCompanionMap
);

    // ==========================================================
    // Elaboration checks
    localparam int NCC   = int'(companions);
    localparam int NPCC  = int'(portsPerCc);
    localparam int NPORT = int'(nPorts);

    generate
        if (NPORT < 1 || NPORT > MAX_PORTS) begin : g_badPorts
            $error("downstream port count out of range");
        end
        if (NCC > 0 && (NPCC == 0 || NCC * NPCC < NPORT
                        || (NCC - 1) * NPCC >= NPORT)) begin : g_badCover
            $error("ports per companion inconsistent with port count");
        end
        if (NCC == 0 && NPCC != 0) begin : g_badNone
            $error("ports per companion must be zero without companions");
        end
        if (int'(capability_byte_length) < 8) begin : g_badLength
            $error("capability length overlaps capability words");
        end
    endgenerate

    // ==========================================================
    // Grouped port-to-companion map, one entry per port
    logic [MAX_PORTS*FIELD_W-1:0] groupedMap;
    logic [MAX_PORTS-1:0]         portMask;

    genvar p;
    generate
        for (p = 0; p < MAX_PORTS; p++) begin : g_port
            localparam int COMP = (NCC > 0 && NPCC > 0 && p < NPORT) ? (p / NPCC) + 1 : 0;
            assign groupedMap[p*FIELD_W +: FIELD_W] = COMP[FIELD_W-1:0];
            assign portMask[p] = (p < NPORT);
        end
    endgenerate

    // ==========================================================
    // Word storage
    logic [DATA_W-1:0] romData;

    cap_word_rom #(
        .versionBcd  (versionBcd),
        .capability_byte_length   (capability_byte_length),
        .companions  (companions),
        .portsPerCc  (portsPerCc),
        .routingRule (routingRule),
        .powerSwitch (powerSwitch),
        .nPorts      (nPorts)
    ) u_rom (
        .core_clk (core_clk),
        .nrst     (nrst),
        .rdEn     (regRead),
        .wordSel  (regAddr[ADDR_W-1:2]),
        .rdData   (romData)
    );

    // ==========================================================
    // State
    typedef struct packed {
        logic                         pending;
        logic                         ack;
        logic [DATA_W-1:0]            rdata;
        logic                         handoff;
        logic                         hsOnly;
        logic                         explicitRoute;
        logic                         powerSw;
        logic [MAX_PORTS-1:0]         portMask;
        logic [MAX_PORTS*FIELD_W-1:0] portMap;
    } cap_state_t;

    cap_state_t state;
    cap_state_t next_state;

    // Write data is deliberately discarded
    logic unusedWdata;
    assign unusedWdata = ^regWdata;

    always_comb begin
        next_state = state;
        // Writes take the same two-cycle path but carry no data
        next_state.pending       = regRead | regWrite;
        next_state.ack           = state.pending;
        next_state.rdata         = state.pending ? romData : WORD_ZERO;
        next_state.handoff       = (companions != 4'h0);
        next_state.hsOnly        = (companions == 4'h0);
        next_state.explicitRoute = routingRule;
        next_state.powerSw       = powerSwitch;
        next_state.portMask      = portMask;
        next_state.portMap       = groupedMap;
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign regRdata           = state.rdata;
    assign regAck             = state.ack;
    assign handoffSupported   = state.handoff;
    assign highSpeedOnly      = state.hsOnly;
    assign explicitRouting    = state.explicitRoute;
    assign powerSwitchPresent = state.powerSw;
    assign portAddressable    = state.portMask;
    assign portCompanionMap   = state.portMap;

    // ==========================================================
    // Assertions
    property p_word0AtZero;
        @(posedge core_clk) disable iff (!nrst)
        (regRead && regAddr == CAP_WORD0_OFFSET) |-> ##2 (regAck && regRdata != WORD_ZERO);
    endproperty
    a_word0AtZero: assert property (p_word0AtZero) else $error("word 0 not at offset zero");

    property p_versionField;
        @(posedge core_clk) disable iff (!nrst)
        (regRead && regAddr == CAP_WORD0_OFFSET) |-> ##2 (regRdata[31:16] == versionBcd);
    endproperty
    a_versionField: assert property (p_versionField) else $error("version field wrong");

    property p_lengthField;
        @(posedge core_clk) disable iff (!nrst)
        (regRead && regAddr == CAP_WORD0_OFFSET)
            |-> ##2 (regRdata[7:0] == capability_byte_length && regRdata[15:8] == 8'h00);
    endproperty
    a_lengthField: assert property (p_lengthField) else $error("length field wrong");

    property p_companionField;
        @(posedge core_clk) disable iff (!nrst)
        (regRead && regAddr == STRUCT_OFFSET) |-> ##2 (regAck && regRdata[15:12] == companions);
    endproperty
    a_companionField: assert property (p_companionField) else $error("companion count wrong");

    property p_noCompanion;
        @(posedge core_clk) disable iff (!nrst)
        $rose(highSpeedOnly) |-> (!handoffSupported && companions == 4'h0);
    endproperty
    a_noCompanion: assert property (p_noCompanion) else $error("high-speed-only flag wrong");

    property p_handoff;
        @(posedge core_clk) disable iff (!nrst)
        regAck |-> (handoffSupported == (companions != 4'h0)) && (highSpeedOnly != handoffSupported);
    endproperty
    a_handoff: assert property (p_handoff) else $error("hand-off flag wrong");

    property p_groupedMap;
        @(posedge core_clk) disable iff (!nrst)
        regAck |-> (companions == 4'h0 || portCompanionMap[FIELD_W-1:0] == 4'h1);
    endproperty
    a_groupedMap: assert property (p_groupedMap) else $error("first port not on companion 1");

    property p_structBits;
        @(posedge core_clk) disable iff (!nrst)
        (regRead && regAddr == STRUCT_OFFSET) |-> ##2 (regRdata[7] == routingRule
            && regRdata[4] == powerSwitch && regRdata[3:0] == nPorts
            && regRdata[11:8] == portsPerCc);
    endproperty
    a_structBits: assert property (p_structBits) else $error("structural bits wrong");

    property p_writeIgnored;
        @(posedge core_clk) disable iff (!nrst)
        (regWrite && !regRead) |-> ##2 (regAck && regRdata == WORD_ZERO);
    endproperty
    a_writeIgnored: assert property (p_writeIgnored) else $error("write returned data");

    property p_reservedZero;
        @(posedge core_clk) disable iff (!nrst)
        (regRead && regAddr == STRUCT_OFFSET) |-> ##2 (regRdata[31:16] == 16'h0000
            && regRdata[6:5] == 2'b00);
    endproperty
    a_reservedZero: assert property (p_reservedZero) else $error("reserved bits set");

endmodule

/* ehci_capability_registers_tb.sv */
`timescale 1ns/10ps

module ehci_capability_registers_tb;
    import ehci_cap_pkg::*;

    // ==========================================================
    // Signals
    logic                         core_clk;
    logic                         nrst;
    logic                         regRead;
    logic                         regWrite;
    logic [ADDR_W-1:0]            regAddr;
    logic [DATA_W-1:0]            regWdata;
    logic [DATA_W-1:0]            rdA;
    logic [DATA_W-1:0]            rdZ;
    logic                         ackA;
    logic                         ackZ;
    logic                         hoA;
    logic                         hsA;
    logic                         erA;
    logic                         psA;
    logic                         hoZ;
    logic                         hsZ;
    logic [MAX_PORTS-1:0]         paA;
    logic [MAX_PORTS*FIELD_W-1:0] cmA;
    logic [MAX_PORTS*FIELD_W-1:0] cmZ;
    logic [32:0]                  p0A, p1A, p0Z, p1Z;
    logic [31:0]                  r;
    int                           n_errors;
    int                           n_compared;
    int                           seed;

    // ==========================================================
    // Design, a companion-free variant, and the host
    ehci_capability_registers dut_u (.core_clk(core_clk), .nrst(nrst), .regRead(regRead),
        .regWrite(regWrite), .regAddr(regAddr), .regWdata(regWdata), .regRdata(rdA),
        .regAck(ackA), .handoffSupported(hoA), .highSpeedOnly(hsA), .explicitRouting(erA),
        .powerSwitchPresent(psA), .portAddressable(paA), .portCompanionMap(cmA));
    ehci_capability_registers #(.companions(4'h0), .portsPerCc(4'h0)) dut_z (
        .core_clk(core_clk), .nrst(nrst), .regRead(regRead), .regWrite(regWrite),
        .regAddr(regAddr), .regWdata(regWdata), .regRdata(rdZ), .regAck(ackZ),
        .handoffSupported(hoZ), .highSpeedOnly(hsZ), .explicitRouting(),
        .powerSwitchPresent(), .portAddressable(), .portCompanionMap(cmZ));
    host_sw_model host_u (.core_clk(core_clk), .regRead(regRead), .regWrite(regWrite),
        .regAddr(regAddr), .regWdata(regWdata));

    always #20 core_clk = ~core_clk;

    // ==========================================================
    // Reference model: {ack, data} for one request
    function automatic logic [32:0] expResp(input int cc, input logic rd, input logic wr,
                                            input logic [7:0] a);
        int w;
        int port_power_switch_present;
        port_power_switch_present = (cc == 0) ? 0 : int'(DOWNSTREAM_PORTS) / cc;
        case (int'(a) >> 2)
            0: w = (int'(VERSION_BCD) << 16) | int'(CAP_BYTE_LENGTH);
            1: w = (cc << 12) | (port_power_switch_present << 8) | (int'(ROUTING_RULE) << 7)
                   | (int'(POWER_SWITCHES) << 4) | int'(DOWNSTREAM_PORTS);
            default: w = 0;
        endcase
        if (!rd) w = 0;
        return {rd | wr, w[31:0]};
    endfunction

    task automatic compare(input string what, input logic [63:0] e, input logic [63:0] g);
        n_compared++;
        if (g !== e) begin
            n_errors++;
            $display("ERROR %s expected %0h seen %0h", what, e, g);
        end
    endtask

    task automatic finish_test;
        if (n_errors == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // ==========================================================
    // Answers are sampled at the second edge after the request,
    // so they stand in the cycle after the second edge
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            {p0A, p1A, p0Z, p1Z} <= '0;
        end else begin
            p0A <= expResp(1, regRead, regWrite, regAddr);
            p0Z <= expResp(0, regRead, regWrite, regAddr);
            p1A <= p0A;
            p1Z <= p0Z;
        end
    end

    always @(negedge core_clk) begin
        compare("regAck", p1A[32], ackA);
        compare("regRdata", p1A[31:0], rdA);
        compare("regAck zero", p1Z[32], ackZ);
        compare("regRdata zero", p1Z[31:0], rdZ);
    end

    task automatic strapCheck(input logic on);
        logic [MAX_PORTS*FIELD_W-1:0] m;
        m = '0;
        for (int p = 0; p < int'(DOWNSTREAM_PORTS); p++)
            m[4*p +: 4] = 4'(p / int'(PORTS_PER_COMP) + 1);
        @(negedge core_clk);
        compare("handoffSupported", on, hoA);
        compare("highSpeedOnly", 0, hsA);
        compare("explicitRouting", on & ROUTING_RULE, erA);
        compare("powerSwitchPresent", on & POWER_SWITCHES, psA);
        compare("portAddressable", on ? (64'h1 << DOWNSTREAM_PORTS) - 1 : 0, paA);
        compare("portCompanionMap", on ? m : '0, cmA);
        compare("handoffSupported zero", 0, hoZ);
        compare("highSpeedOnly zero", on, hsZ);
        compare("portCompanionMap zero", 0, cmZ);
    endtask

    // ==========================================================
    // Stimulus
    initial begin
        seed = 19747;
        n_errors = 0;
        n_compared = 0;
        core_clk = 1'b0;
        nrst = 1'b0;
        repeat (20) @(posedge core_clk);
        strapCheck(1'b0);
        @(posedge core_clk);
        nrst <= 1'b1;
        // Back-to-back reads, low address bits set on the first two
        host_u.access(1'b1, 1'b0, 8'h01, '0);
        host_u.access(1'b1, 1'b0, 8'h07, '0);
        host_u.access(1'b1, 1'b0, 8'h00, '0);
        // Writes must not disturb the constants
        host_u.access(1'b0, 1'b1, 8'h00, 32'hFFFFFFFF);
        host_u.access(1'b0, 1'b1, 8'h04, 32'hFFFFFFFF);
        host_u.access(1'b1, 1'b1, 8'h04, 32'hFFFFFFFF);
        host_u.access(1'b1, 1'b0, 8'h00, '0);
        for (int a = 8; a < 256; a += 4)
            host_u.access(1'b1, 1'b0, 8'(a), '0);
        repeat (300) begin
            r = $random(seed);
            host_u.access(r[31], r[30], {3'h0, r[12:8]}, $random(seed));
        end
        host_u.idle(4);
        strapCheck(1'b1);
        // Reset asserts at the same edge a request is issued
        host_u.access(1'b1, 1'b0, 8'h04, '0);
        nrst <= 1'b0;
        host_u.idle(3);
        strapCheck(1'b0);
        @(posedge core_clk);
        nrst <= 1'b1;
        host_u.access(1'b1, 1'b0, 8'h00, '0);
        host_u.idle(4);
        strapCheck(1'b1);
        finish_test();
    end

    // Run needs about 405 cycles
    initial begin
        #(40 * 3000);
        n_errors++;
        finish_test();
    end
endmodule

/* host_sw_model.sv */
`timescale 1ns/10ps

module host_sw_model
    import ehci_cap_pkg::*;
(
    // Clock
    input  wire logic              core_clk,
    // Requests toward the bank
    output logic                   regRead,
    output logic                   regWrite,
    output logic [ADDR_W-1:0]      regAddr,
    output logic [DATA_W-1:0]      regWdata
);
    // ==========================================================
    // Host side of the register bus
    initial begin
        regRead  = 1'b0;
        regWrite = 1'b0;
        regAddr  = 8'hA5;
        regWdata = 32'h5A5A5A5A;
    end

    // One request per call, held for exactly one edge
    task automatic access(input logic rd, input logic wr,
                          input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge core_clk);
        regRead  <= rd;
        regWrite <= wr;
        regAddr  <= a;
        regWdata <= d;
    endtask

    // Released bus toggles so a stale address is never trusted
    task automatic idle(input int n);
        repeat (n) begin
            @(posedge core_clk);
            regRead  <= 1'b0;
            regWrite <= 1'b0;
            regAddr  <= ~regAddr;
            regWdata <= ~regWdata;
        end
    endtask
endmodule
